//--- hdl/adc_result_pkg.sv
package adc_result_pkg;

  localparam logic [7:0]  OFS_INPUT_VOLTAGE   = 8'h23;
  localparam logic [7:0]  OFS_SYSTEM_VOLTAGE  = 8'h25;
  localparam logic [7:0]  OFS_INPUT_CURRENT   = 8'h27;
  localparam logic [7:0]  OFS_DIE_TEMPERATURE = 8'h29;
  localparam logic [7:0]  OFS_FIRST_ALARM     = 8'h2b;
  localparam logic [7:0]  OFS_SECOND_ALARM    = 8'h2d;

  localparam logic [15:0] RESULT_RESET        = 16'h0000;
  localparam logic [15:0] FIRST_ALARM_RESET   = 16'h2900;
  localparam logic [15:0] SECOND_ALARM_RESET  = 16'h41c0;
  localparam logic [11:0] FIRST_THRESH_RESET  = 12'h290;
  localparam logic [11:0] SECOND_THRESH_RESET = 12'h41c;

  localparam int          THRESH_MSB          = 15;
  localparam int          THRESH_LSB          = 4;
  localparam int          POLARITY_BIT        = 3;

  // full-scale codes: 6000/1.5, 20000/5, 5000/1.25, 1100/0.5
  localparam logic [15:0] INPUT_VOLTAGE_LOW_MAX  = 16'h0fa0;
  localparam logic [15:0] INPUT_VOLTAGE_HIGH_MAX = 16'h0fa0;
  localparam logic [15:0] SYSTEM_VOLTAGE_MAX     = 16'h0fa0;
  localparam logic [15:0] INPUT_CURRENT_MAX      = 16'h0898;

  // channel select codes of a comparator
  localparam logic [2:0]  CH_DIE_TEMPERATURE  = 3'h0;
  localparam logic [2:0]  CH_INPUT_VOLTAGE    = 3'h5;
  localparam logic [2:0]  CH_SYSTEM_VOLTAGE   = 3'h6;
  localparam logic [2:0]  CH_INPUT_CURRENT    = 3'h7;

  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_HIGH = 3'b010,
    WR_DONE = 3'b100
  } write_state_t;

endpackage : adc_result_pkg

//--- hdl/alarm_comparator.sv
`timescale 1ns/1ps
`default_nettype none
// one threshold comparator; fires a single pulse on entry into alarm
module alarm_comparator (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [11:0] threshold_i,
  input  wire logic        polarity_i,
  input  wire logic        sample_valid_i,
  input  wire logic [15:0] sample_i,
  output logic             alarm_pulse_o
);

  logic [11:0] sample_top;
  logic        cond;
  logic        cond_r;

  assign sample_top = sample_i[adc_result_pkg::THRESH_MSB:adc_result_pkg::THRESH_LSB];
  assign cond = polarity_i ? (sample_top >= threshold_i)
                           : (sample_top <  threshold_i);

  // edge detect so a lasting alarm does not keep firing
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cond_r        <= 1'b0;
      alarm_pulse_o <= 1'b0;
    end else begin
      alarm_pulse_o <= 1'b0;
      if (sample_valid_i) begin
        cond_r        <= cond;
        alarm_pulse_o <= cond && !cond_r;
      end
    end
  end

  property p_fires_on_entry;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      alarm_pulse_o |-> $past(sample_valid_i) && $past(cond) && !$past(cond_r);
  endproperty
  a_fires_on_entry: assert property (p_fires_on_entry) else $error("alarm without entry");

endmodule : alarm_comparator
`default_nettype wire

//--- hdl/adc_result_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - input-voltage result RO at 0x23, resets zero
// - input-voltage span per range, clamped high
// - input-voltage step 1.5 mV or 5 mV
// - system-voltage result RO at 0x25, resets zero
// - system voltage 1.25 mV steps, clamp 0xfa0
// - input-current result RO at 0x27, resets zero
// - input current 0.5 mA steps, clamp 0x898
// - die-temperature result RO at 0x29, resets zero
// - die temperature two's complement, 0.5 C steps
// - first alarm register 0x2b resets 0x2900
// - first threshold bits 15:4, resets 0x290
// - polarity 0 fires when below threshold
// - polarity 1 fires when at or above
// - second alarm register 0x2d resets 0x41c0
// - second threshold and polarity; bits 2:0 zero
module adc_result_regs #(
  parameter int RESULT_W = 16
) (
  input  wire logic                ref_clk_i,
  input  wire logic                reset_n_i,
  // register port: byte-wide, a 16-bit register takes offset then offset+1
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  output logic      [7:0]          reg_rdata_o,
  output logic                     reg_ack_o,
  // register reset from the device's reset control
  input  wire logic                reg_reset_i,
  input  wire logic                input_overvoltage_range_select_i,
  // raw converter results, already in result lsb units of each range
  input  wire logic                conv_valid_i,
  input  wire logic [RESULT_W-1:0] input_voltage_raw_i,
  input  wire logic [RESULT_W-1:0] system_voltage_raw_i,
  input  wire logic [RESULT_W-1:0] input_current_raw_i,
  input  wire logic [RESULT_W-1:0] die_temperature_raw_i,
  input  wire logic [2:0]          first_channel_i,
  input  wire logic [2:0]          second_channel_i,
  output logic                     first_alarm_o,
  output logic                     second_alarm_o
);

  logic                 rst_sync1_r;
  logic                 rst_n;
  logic [RESULT_W-1:0]  input_voltage_r;
  logic [RESULT_W-1:0]  system_voltage_r;
  logic [RESULT_W-1:0]  input_current_r;
  logic [RESULT_W-1:0]  die_temperature_r;
  logic [11:0]          first_thresh_r;
  logic                 first_pol_r;
  logic [11:0]          second_thresh_r;
  logic                 second_pol_r;
  logic [7:0]           wr_low_r;
  logic [7:0]           wr_addr_r;
  logic [7:0]           rd_high_r;
  logic                 res_valid_r;
  logic [RESULT_W-1:0]  input_voltage_max;
  logic [RESULT_W-1:0]  first_sample;
  logic [RESULT_W-1:0]  second_sample;
  logic [15:0]          reg_word;
  logic [7:0]           rd_base;
  adc_result_pkg::write_state_t wr_state_r;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync1_r <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_n       <= rst_sync1_r;
    end
  end

  // both ranges span 4000 codes: 6000/1.5 and 20000/5
  assign input_voltage_max = input_overvoltage_range_select_i
                             ? adc_result_pkg::INPUT_VOLTAGE_HIGH_MAX
                             : adc_result_pkg::INPUT_VOLTAGE_LOW_MAX;

  // results capture clamped values, die temperature unclamped; cleared to zero by the register reset too
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      input_voltage_r   <= adc_result_pkg::RESULT_RESET;
      system_voltage_r  <= adc_result_pkg::RESULT_RESET;
      input_current_r   <= adc_result_pkg::RESULT_RESET;
      die_temperature_r <= adc_result_pkg::RESULT_RESET;
      res_valid_r       <= 1'b0;
    end else if (reg_reset_i) begin
      input_voltage_r   <= adc_result_pkg::RESULT_RESET;
      system_voltage_r  <= adc_result_pkg::RESULT_RESET;
      input_current_r   <= adc_result_pkg::RESULT_RESET;
      die_temperature_r <= adc_result_pkg::RESULT_RESET;
      res_valid_r       <= 1'b0;
    end else begin
      res_valid_r <= conv_valid_i;
      if (conv_valid_i) begin
        input_voltage_r   <= (input_voltage_raw_i > input_voltage_max) ? input_voltage_max
                                                                       : input_voltage_raw_i;
        system_voltage_r  <= (system_voltage_raw_i > adc_result_pkg::SYSTEM_VOLTAGE_MAX)
                             ? adc_result_pkg::SYSTEM_VOLTAGE_MAX : system_voltage_raw_i;
        input_current_r   <= (input_current_raw_i > adc_result_pkg::INPUT_CURRENT_MAX)
                             ? adc_result_pkg::INPUT_CURRENT_MAX : input_current_raw_i;
        die_temperature_r <= die_temperature_raw_i;
      end
    end
  end

  // two-byte write: low address latches the high byte, next address commits
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_state_r <= adc_result_pkg::WR_IDLE;
      wr_low_r   <= 8'h00;
      wr_addr_r  <= 8'h00;
    end else begin
      case (wr_state_r)
        adc_result_pkg::WR_IDLE: begin
          if (reg_wr_i) begin
            wr_low_r   <= reg_wdata_i;
            wr_addr_r  <= reg_addr_i;
            wr_state_r <= adc_result_pkg::WR_HIGH;
          end
        end
        adc_result_pkg::WR_HIGH: begin
          if (reg_wr_i) begin
            wr_state_r <= (reg_addr_i == wr_addr_r + 8'h01) ? adc_result_pkg::WR_DONE
                                                             : adc_result_pkg::WR_HIGH;
            if (reg_addr_i != wr_addr_r + 8'h01) begin
              wr_low_r  <= reg_wdata_i;
              wr_addr_r <= reg_addr_i;
            end
          end
        end
        adc_result_pkg::WR_DONE: begin
          wr_state_r <= adc_result_pkg::WR_IDLE;
        end
        default: begin
          wr_state_r <= adc_result_pkg::WR_IDLE;
        end
      endcase
    end
  end

  logic commit;
  assign commit = (wr_state_r == adc_result_pkg::WR_HIGH) && reg_wr_i
                  && (reg_addr_i == wr_addr_r + 8'h01);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      first_thresh_r  <= adc_result_pkg::FIRST_THRESH_RESET;
      first_pol_r     <= 1'b0;
      second_thresh_r <= adc_result_pkg::SECOND_THRESH_RESET;
      second_pol_r    <= 1'b0;
    end else if (reg_reset_i) begin
      first_thresh_r  <= adc_result_pkg::FIRST_THRESH_RESET;
      first_pol_r     <= 1'b0;
      second_thresh_r <= adc_result_pkg::SECOND_THRESH_RESET;
      second_pol_r    <= 1'b0;
    end else if (commit) begin
      // register word is {high byte at offset, low byte at offset+1}
      if (wr_addr_r == adc_result_pkg::OFS_FIRST_ALARM) begin
        first_thresh_r <= {wr_low_r, reg_wdata_i[7:4]};
        first_pol_r    <= reg_wdata_i[adc_result_pkg::POLARITY_BIT];
      end
      if (wr_addr_r == adc_result_pkg::OFS_SECOND_ALARM) begin
        second_thresh_r <= {wr_low_r, reg_wdata_i[7:4]};
        second_pol_r    <= reg_wdata_i[adc_result_pkg::POLARITY_BIT];
      end
    end
  end

  // read mux: high byte at the printed offset, low byte at the next one
  assign rd_base = reg_addr_i[0] ? reg_addr_i : reg_addr_i - 8'h01;

  always_comb begin
    case (rd_base)
      adc_result_pkg::OFS_INPUT_VOLTAGE:   reg_word = input_voltage_r;
      adc_result_pkg::OFS_SYSTEM_VOLTAGE:  reg_word = system_voltage_r;
      adc_result_pkg::OFS_INPUT_CURRENT:   reg_word = input_current_r;
      adc_result_pkg::OFS_DIE_TEMPERATURE: reg_word = die_temperature_r;
      adc_result_pkg::OFS_FIRST_ALARM:     reg_word = {first_thresh_r, first_pol_r, 3'h0};
      adc_result_pkg::OFS_SECOND_ALARM:    reg_word = {second_thresh_r, second_pol_r, 3'h0};
      default:                             reg_word = 16'h0000;
    endcase
  end

  // low byte is snapshotted with the high byte so a 16-bit read is coherent
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
      rd_high_r   <= 8'h00;
      reg_ack_o   <= 1'b0;
    end else begin
      reg_ack_o <= reg_rd_i | reg_wr_i;
      if (reg_rd_i) begin
        if (reg_addr_i[0]) begin
          reg_rdata_o <= reg_word[15:8];
          rd_high_r   <= reg_word[7:0];
        end else begin
          reg_rdata_o <= rd_high_r;
        end
      end
    end
  end

  function automatic logic [RESULT_W-1:0] pick(input logic [2:0] ch,
                                                 input logic [RESULT_W-1:0] in_volt,
                                                 input logic [RESULT_W-1:0] sys_volt,
                                                 input logic [RESULT_W-1:0] in_curr,
                                                 input logic [RESULT_W-1:0] die_temp);
    case (ch)
      adc_result_pkg::CH_INPUT_VOLTAGE:  pick = in_volt;
      adc_result_pkg::CH_SYSTEM_VOLTAGE: pick = sys_volt;
      adc_result_pkg::CH_INPUT_CURRENT:  pick = in_curr;
      default:                           pick = die_temp;
    endcase
  endfunction : pick

  assign first_sample  = pick(first_channel_i, input_voltage_r, system_voltage_r,
                              input_current_r, die_temperature_r);
  assign second_sample = pick(second_channel_i, input_voltage_r, system_voltage_r,
                              input_current_r, die_temperature_r);

  alarm_comparator u_first (
    .ref_clk_i      (ref_clk_i),
    .rst_n_i        (rst_n),
    .threshold_i    (first_thresh_r),
    .polarity_i     (first_pol_r),
    .sample_valid_i (res_valid_r),
    .sample_i       (first_sample),
    .alarm_pulse_o  (first_alarm_o)
  );

  alarm_comparator u_second (
    .ref_clk_i      (ref_clk_i),
    .rst_n_i        (rst_n),
    .threshold_i    (second_thresh_r),
    .polarity_i     (second_pol_r),
    .sample_valid_i (res_valid_r),
    .sample_i       (second_sample),
    .alarm_pulse_o  (second_alarm_o)
  );

  sequence s_valid_sample;
    conv_valid_i && !reg_reset_i;
  endsequence

  property p_system_clamp;
    @(posedge ref_clk_i) disable iff (!rst_n)
      s_valid_sample |=> system_voltage_r <= adc_result_pkg::SYSTEM_VOLTAGE_MAX;
  endproperty
  a_system_clamp: assert property (p_system_clamp) else $error("system voltage clamp");

  property p_current_clamp;
    @(posedge ref_clk_i) disable iff (!rst_n)
      s_valid_sample ##1 1'b1 |-> input_current_r ==
        (($past(input_current_raw_i) > adc_result_pkg::INPUT_CURRENT_MAX)
         ? adc_result_pkg::INPUT_CURRENT_MAX : $past(input_current_raw_i));
  endproperty
  a_current_clamp: assert property (p_current_clamp) else $error("current not clamped");

  property p_input_clamp;
    @(posedge ref_clk_i) disable iff (!rst_n)
      s_valid_sample |=> input_voltage_r <= adc_result_pkg::INPUT_VOLTAGE_HIGH_MAX;
  endproperty
  a_input_clamp: assert property (p_input_clamp) else $error("input voltage above span");

  property p_temp_pass;
    @(posedge ref_clk_i) disable iff (!rst_n)
      s_valid_sample |=> die_temperature_r == $past(die_temperature_raw_i);
  endproperty
  a_temp_pass: assert property (p_temp_pass) else $error("die temperature altered");

  property p_regreset_results;
    @(posedge ref_clk_i) disable iff (!rst_n)
      reg_reset_i |=> input_voltage_r == 16'h0000 && input_current_r == 16'h0000;
  endproperty
  a_regreset_results: assert property (p_regreset_results) else $error("results kept");

  property p_regreset_thresh;
    @(posedge ref_clk_i) disable iff (!rst_n)
      reg_reset_i |=> {first_thresh_r, first_pol_r, 3'h0} == adc_result_pkg::FIRST_ALARM_RESET
        && {second_thresh_r, second_pol_r, 3'h0} == adc_result_pkg::SECOND_ALARM_RESET;
  endproperty
  a_regreset_thresh: assert property (p_regreset_thresh) else $error("alarm reset wrong");

  property p_below_fires;
    @(posedge ref_clk_i) disable iff (!rst_n)
      first_alarm_o && !$past(first_pol_r) |->
        $past(first_sample[15:4]) < $past(first_thresh_r);
  endproperty
  a_below_fires: assert property (p_below_fires) else $error("low alarm while not below");

  property p_above_fires;
    @(posedge ref_clk_i) disable iff (!rst_n)
      second_alarm_o && $past(second_pol_r) |->
        $past(second_sample[15:4]) >= $past(second_thresh_r);
  endproperty
  a_above_fires: assert property (p_above_fires) else $error("high alarm while below");

  property p_ack_follows;
    @(posedge ref_clk_i) disable iff (!rst_n)
      reg_rd_i || reg_wr_i |=> reg_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("strobe not acknowledged");

  property p_results_hold;
    @(posedge ref_clk_i) disable iff (!rst_n)
      !conv_valid_i && !reg_reset_i |=> $stable(input_voltage_r) && $stable(system_voltage_r)
        && $stable(input_current_r) && $stable(die_temperature_r);
  endproperty
  a_results_hold: assert property (p_results_hold) else $error("result changed by host");

  property p_regreset_others;
    @(posedge ref_clk_i) disable iff (!rst_n)
      reg_reset_i |=> system_voltage_r == 16'h0000 && die_temperature_r == 16'h0000;
  endproperty
  a_regreset_others: assert property (p_regreset_others) else $error("results kept");

  property p_first_high_read;
    @(posedge ref_clk_i) disable iff (!rst_n)
      reg_rd_i && reg_addr_i == adc_result_pkg::OFS_FIRST_ALARM |=>
        reg_rdata_o == $past(first_thresh_r[11:4]);
  endproperty
  a_first_high_read: assert property (p_first_high_read) else $error("threshold byte wrong");

  sequence s_second_pair_read;
    reg_rd_i && reg_addr_i == adc_result_pkg::OFS_SECOND_ALARM
      ##1 reg_rd_i && reg_addr_i == adc_result_pkg::OFS_SECOND_ALARM + 8'h01;
  endsequence
  property p_reserved_zero;
    @(posedge ref_clk_i) disable iff (!rst_n)
      s_second_pair_read |=> reg_rdata_o[2:0] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  sequence s_first_pair_write;
    reg_wr_i && reg_addr_i == adc_result_pkg::OFS_FIRST_ALARM
      && wr_state_r == adc_result_pkg::WR_IDLE
      ##1 reg_wr_i && reg_addr_i == adc_result_pkg::OFS_FIRST_ALARM + 8'h01 && !reg_reset_i;
  endsequence
  property p_first_commit;
    @(posedge ref_clk_i) disable iff (!rst_n)
      s_first_pair_write |=>
        first_thresh_r == {$past(reg_wdata_i, 2), $past(reg_wdata_i[7:4])}
        && first_pol_r == $past(reg_wdata_i[adc_result_pkg::POLARITY_BIT]);
  endproperty
  a_first_commit: assert property (p_first_commit) else $error("threshold write lost");

  property p_second_below;
    @(posedge ref_clk_i) disable iff (!rst_n)
      second_alarm_o && !$past(second_pol_r) |->
        $past(second_sample[15:4]) < $past(second_thresh_r);
  endproperty
  a_second_below: assert property (p_second_below) else $error("alarm while not below");

  property p_first_above;
    @(posedge ref_clk_i) disable iff (!rst_n)
      first_alarm_o && $past(first_pol_r) |->
        $past(first_sample[15:4]) >= $past(first_thresh_r);
  endproperty
  a_first_above: assert property (p_first_above) else $error("alarm while below");

endmodule : adc_result_regs
`default_nettype wire

//--- bench/reg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// byte-port host; every change lands on the falling edge, away from sampling
module reg_host_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_ack_i,
  output var  logic       reg_wr_o,
  output var  logic       reg_rd_o,
  output var  logic [7:0] reg_addr_o,
  output var  logic [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // released lines flip so a stale value can never pass for a live one
  task automatic release_bus();
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
    @(negedge ref_clk_i);
  endtask : release_bus
  task automatic wr_word(input logic [7:0] ofs, input logic [15:0] w, output logic ok);
    @(negedge ref_clk_i);
    reg_wr_o    = 1'b1;
    reg_addr_o  = ofs;
    reg_wdata_o = w[15:8];
    @(negedge ref_clk_i);
    ok          = reg_ack_i;
    reg_addr_o  = ofs + 8'h01;
    reg_wdata_o = w[7:0];
    @(negedge ref_clk_i);
    ok          = ok & reg_ack_i;
    release_bus();
  endtask : wr_word
  // high byte first: it snapshots the low byte
  task automatic rd_word(input logic [7:0] ofs, output logic [15:0] w, output logic ok);
    @(negedge ref_clk_i);
    reg_rd_o   = 1'b1;
    reg_addr_o = ofs;
    @(negedge ref_clk_i);
    ok         = reg_ack_i;
    w[15:8]    = reg_rdata_i;
    reg_addr_o = ofs + 8'h01;
    @(negedge ref_clk_i);
    ok         = ok & reg_ack_i;
    w[7:0]     = reg_rdata_i;
    release_bus();
  endtask : rd_word
endmodule : reg_host_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        ref_clk_i  = 1'b0;
  logic        reset_n_i  = 1'b0;
  logic        reg_wr, reg_rd, reg_ack, ok;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_reset  = 1'b0;
  logic        ovp_sel    = 1'b0;
  logic        conv_valid = 1'b0;
  logic [15:0] raw [4]    = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [2:0]  chs [2]    = '{3'h5, 3'h6};
  logic        alarm [2];
  logic [11:0] thr [2];
  logic        pol [2];
  logic        prev [2];
  logic [15:0] got;
  logic [7:0]  ofs [6]    = '{8'h23, 8'h25, 8'h27, 8'h29, 8'h2b, 8'h2d};
  int          err_total  = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  adc_result_regs dut_u (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .reg_ack_o(reg_ack), .reg_reset_i(reg_reset), .input_overvoltage_range_select_i(ovp_sel),
    .conv_valid_i(conv_valid), .input_voltage_raw_i(raw[0]), .system_voltage_raw_i(raw[1]),
    .input_current_raw_i(raw[2]), .die_temperature_raw_i(raw[3]),
    .first_channel_i(chs[0]), .second_channel_i(chs[1]),
    .first_alarm_o(alarm[0]), .second_alarm_o(alarm[1]));
  reg_host_model host_u (
    .ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata), .reg_ack_i(reg_ack),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

  always #12.5 ref_clk_i = ~ref_clk_i;
  // the whole run needs about 1600 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic exp, input logic seen);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk_bit

  // clamp per channel; die temperature passes unclamped
  function automatic logic [15:0] exp_result(int k, logic [15:0] r);
    case (k)
      0, 1:    return (r > 16'h0fa0) ? 16'h0fa0 : r;
      2:       return (r > 16'h0898) ? 16'h0898 : r;
      default: return r;
    endcase
  endfunction : exp_result
  function automatic logic in_alarm(int i);
    int          k;
    logic [15:0] s;
    // channel codes below 5 select the die temperature
    k = (chs[i] >= 3'h5) ? int'(chs[i]) - 5 : 3;
    s = exp_result(k, raw[k]);
    return pol[i] ? (s[15:4] >= thr[i]) : (s[15:4] < thr[i]);
  endfunction : in_alarm

  task automatic rd_chk(input int k, input logic [15:0] exp);
    host_u.rd_word(ofs[k], got, ok);
    chk_bit("ack", 1'b1, ok);
    chk_word("register", exp, got);
  endtask : rd_chk
  task automatic set_comp(input int i, input logic [11:0] t, input logic p, input logic [2:0] c);
    host_u.wr_word(ofs[4+i], {t, p, 3'($urandom)}, ok);
    thr[i] = t;
    pol[i] = p;
    chs[i] = c;
    rd_chk(4 + i, {t, p, 3'b000});
  endtask : set_comp
  task automatic conv(input logic check);
    logic c [2];
    @(negedge ref_clk_i);
    conv_valid = 1'b1;
    @(negedge ref_clk_i);
    conv_valid = 1'b0;
    // the alarm pulse stands for one cycle, two edges after the strobe
    @(negedge ref_clk_i);
    for (int i = 0; i < 2; i++) begin
      c[i] = in_alarm(i);
      if (check)
        chk_bit("alarm", c[i] && !prev[i], alarm[i]);
      prev[i] = c[i];
    end
    for (int k = 0; k < 4; k++)
      rd_chk(k, exp_result(k, raw[k]));
  endtask : conv
  task automatic chk_defaults();
    for (int k = 0; k < 6; k++)
      rd_chk(k, (k == 4) ? 16'h2900 : (k == 5) ? 16'h41c0 : 16'h0000);
  endtask : chk_defaults

  initial begin
    void'($urandom(32'he837));
    repeat (2) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk_defaults();
    host_u.rd_word(8'h31, got, ok);
    chk_word("unmapped", 16'h0000, got);
    host_u.wr_word(8'h23, 16'ha5c3, ok);
    rd_chk(0, 16'h0000);
    for (int round = 0; round < 8; round++) begin
      set_comp(0, 12'($urandom_range(0, 12'h0fa)), 1'($urandom), 3'($urandom_range(4, 7)));
      set_comp(1, 12'($urandom_range(0, 12'h0fa)), 1'($urandom), 3'($urandom_range(4, 7)));
      for (int n = 0; n < 9; n++) begin
        for (int k = 0; k < 3; k++)
          raw[k] = 16'($urandom_range(0, 16'h1400));
        raw[3] = 16'($urandom);
        ovp_sel = 1'($urandom);
        conv(n != 0);
      end
    end
    // exact equality at the clamp top fires once, a still larger input does not again
    set_comp(0, 12'h0fa, 1'b1, 3'h5);
    raw[0] = 16'h0f9f;
    conv(1'b0);
    raw[0] = 16'h0fa0;
    conv(1'b1);
    raw[0] = 16'hffff;
    conv(1'b1);
    @(negedge ref_clk_i);
    reg_reset = 1'b1;
    @(negedge ref_clk_i);
    reg_reset = 1'b0;
    chk_defaults();
    conclude();
  end
endmodule : tb
`default_nettype wire
